// >>> pcipt_pkg.sv
// pcipt_pkg: constants, states and carrier types of the pass-through target.
// assumes the pci bus and the add-on logic both run on the one 40 MHz clock.
package pcipt_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int WFIFO_DEPTH = 8;
  localparam int RBUF_DEPTH = 2;
  localparam int DEC_COUNT = 3;
  localparam int OPREG_SLOT = 2;

  // ----------------------------------------------------------------
  // latency limits, in pci clocks, and dword address step
  // ----------------------------------------------------------------
  localparam logic [4:0] FIRST_LAT = 5'h10;
  localparam logic [4:0] NEXT_LAT = 5'h08;
  localparam logic [31:0] DWORD_STEP = 32'h0000_0004;

  // ----------------------------------------------------------------
  // decode windows: slots 0 and 1 are pass-through regions, slot 2 the op registers
  // ----------------------------------------------------------------
  localparam logic [31:0] DEC_BASE [DEC_COUNT] = '{32'h0001_0000, 32'h0002_0000, 32'h0003_0000};
  localparam logic [31:0] DEC_MASK [DEC_COUNT] = '{32'hFFFF_F000, 32'hFFFF_FE00, 32'hFFFF_FFC0};
  localparam logic [1:0] REGION_CODE_A = 2'h1;
  localparam logic [1:0] REGION_CODE_B = 2'h2;

  // ----------------------------------------------------------------
  // op status word: write level in [3:0], read held bit 4, read request bit 5
  // ----------------------------------------------------------------
  localparam int OPST_HELD_BIT = 4;
  localparam int OPST_REQ_BIT = 5;
  localparam logic [31:0] OPST_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_READ = 3'b010,
    ST_OPREG = 3'b011,
    ST_STOP = 3'b100,
    ST_TURN = 3'b101
  } pcipt_state_t;

  typedef struct packed {
    logic frameN;
    logic irdyN;
    logic [3:0] cbeN;
    logic [31:0] ad;
  } pcipt_pci_in_t;

  typedef struct packed {
    logic devselN;
    logic trdyN;
    logic stopN;
    logic ctlOe;
    logic [31:0] ad;
    logic adOe;
  } pcipt_pci_out_t;

  typedef struct packed {
    logic accessPendingN;
    logic burstN;
    logic [1:0] region;
    logic isWrite;
    logic [3:0] beN;
  } pcipt_status_t;

endpackage : pcipt_pkg

// >>> pcipt_fifo.sv
// pcipt_fifo: valid/ready buffer, width and depth set by parameters.
// assumes DEPTH is a power of two; both sides on clk.
`timescale 1ns/1ps
module pcipt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic inValid, // word offered
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word in
  output logic outValid, // word held
  input wire logic outReady, // drain takes word
  output logic [WIDTH-1:0] outData, // head word
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] level_r;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  assign inReady = level_r != (AW+1)'(DEPTH);
  assign outValid = level_r != '0;
  assign outData = mem[rdPtr_r];
  assign level = level_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + AW'(push);
      rdPtr_r <= rdPtr_r + AW'(pop);
      level_r <= level_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pcipt_fifo

// >>> pcipt_window_dec.sv
// pcipt_window_dec: one address window compare, base under mask.
// assumes base bits outside the mask are zero.
`timescale 1ns/1ps
module pcipt_window_dec #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] MASK = 32'hFFFF_F000
) (
  input wire logic [31:0] addr, // address to test
  output logic hit // address in window
);
  assign hit = (addr & MASK) == BASE;
endmodule : pcipt_window_dec

// >>> pcipt_target.sv
// pcipt_target: pci target side of the pass-through channel.
// assumes pci pins and add-on logic are synchronous to clk; pin tristate outside.
// How it works
// - claim cycles hitting a pass-through region
// - start add-on transfer only when idle
// - sample address, claim, capture address
// - writes: trdy at once into fifo
// - reads: request add-on, fetch one dword
// - detect bursts from frame and irdy
// - accept eight dwords before add-on drains
// - captured address steps each pass-through data phase
// - burst reads request next, drive data
// - first read phase over sixteen: retry
// - later read phase over eight: disconnect
// - retry is stop without any trdy
// - disconnect is stop after a transfer
// - leaving the region forces a disconnect
// - unmapped addresses never get devsel
// - write disconnect on full, retry on busy
// - continuing write resumes without disconnect
// - op registers served while add-on busy
// - add-on reads captured address directly
// - write fifo eight by thirty-two
// - pending output flags access needing service
`timescale 1ns/1ps
module pcipt_target (
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // sync reset, high
  input wire pcipt_pkg::pcipt_pci_in_t pciIn, // sampled pci pins
  output pcipt_pkg::pcipt_pci_out_t pciOut, // pci drive and enables
  output pcipt_pkg::pcipt_status_t addonStatus, // pass-through status
  output logic wrOutValid, // posted write word ready
  input wire logic wrOutReady, // add-on takes word
  output logic [31:0] wrOutData, // posted write word
  input wire logic rdInValid, // add-on read word
  output logic rdInReady, // read word wanted
  input wire logic [31:0] rdInData, // read word
  input wire logic directAddressReadN, // direct address read, low
  output logic [31:0] addrBusOut, // captured address
  output logic addrBusOe // drive captured address
);
  import pcipt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcipt_state_t state_r, state_nxt;
  logic [31:0] capturedAddressReg_r, capturedAddressReg_nxt;
  logic [31:0] wrAddrNext_r, wrAddrNext_nxt;
  logic [31:0] readAddr_r, readAddr_nxt;
  logic [31:0] adOut_r, adOut_nxt;
  logic [4:0] latCnt_r, latCnt_nxt;
  logic [3:0] beN_r, beN_nxt;
  logic [1:0] region_r, region_nxt;
  logic isWrite_r, isWrite_nxt;
  logic burst_r, burst_nxt;
  logic firstPhase_r, firstPhase_nxt;
  logic readReq_r, readReq_nxt;
  logic devselN_r, devselN_nxt;
  logic trdyN_r, trdyN_nxt;
  logic stopN_r, stopN_nxt;
  logic ctlOe_r, ctlOe_nxt;
  logic adOe_r, adOe_nxt;
  logic busIdle_r;
  logic darMeta_r;
  logic darSync_r;
  logic addrBusOe_r;
  pcipt_status_t status_r;
  logic wfPush;
  logic rdPop;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [DEC_COUNT-1:0] hitVec;

  for (genvar g = 0; g < DEC_COUNT; g++) begin : g_dec
    pcipt_window_dec #(
      .BASE(DEC_BASE[g]),
      .MASK(DEC_MASK[g])
    ) u_dec (
      .addr(pciIn.ad),
      .hit(hitVec[g])
    );
  end

  wire addrPhase = busIdle_r & ~pciIn.frameN;
  wire ptHit = hitVec[0] | hitVec[1];
  wire opHit = hitVec[OPREG_SLOT];
  wire [1:0] hitRegion = hitVec[0] ? REGION_CODE_A : REGION_CODE_B;
  wire cmdWrite = pciIn.cbeN[0];
  wire xfer = ~pciIn.irdyN & ~trdyN_r;
  wire [31:0] capPlus4 = capturedAddressReg_r + DWORD_STEP;
  wire regSel = region_r == REGION_CODE_B;
  wire nextInRegion = (capPlus4 & DEC_MASK[regSel]) == DEC_BASE[regSel];
  wire [4:0] latLimit = firstPhase_r ? FIRST_LAT : NEXT_LAT;
  wire latExpired = latCnt_r == latLimit - 5'h01;

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  logic wfInReady;
  logic [3:0] wfLevel;
  logic rbValid;
  logic [31:0] rbData;
  logic rbInReady;
  logic [1:0] rbLevel;

  pcipt_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(WFIFO_DEPTH)
  ) u_wfifo (
    .clk(clk),
    .rst(rst),
    .inValid(wfPush),
    .inReady(wfInReady),
    .inData(pciIn.ad),
    .outValid(wrOutValid),
    .outReady(wrOutReady),
    .outData(wrOutData),
    .level(wfLevel)
  );

  // read words pass a two-entry buffer so a pci stall drops nothing
  pcipt_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(RBUF_DEPTH)
  ) u_rbuf (
    .clk(clk),
    .rst(rst),
    .inValid(rdInValid & readReq_r),
    .inReady(rbInReady),
    .inData(rdInData),
    .outValid(rbValid),
    .outReady(rdPop),
    .outData(rbData),
    .level(rbLevel)
  );

  assign rdInReady = readReq_r & rbInReady;
  wire rdInFire = rdInValid & rdInReady;
  wire wrBusy = wfLevel != 4'h0;
  wire rdBusy = readReq_r | rbValid;
  // write at expected next address continues, unless fifo is full
  wire wrAccept = ~rdBusy & wfInReady & (~wrBusy | (pciIn.ad == wrAddrNext_r));
  // held read data serves only the matching address
  wire rdAccept = ~wrBusy & (~rdBusy | (pciIn.ad == readAddr_r));
  wire [3:0] wfAfterPush = wfLevel + 4'h1 - {3'h0, wrOutValid & wrOutReady};
  // trdy stays on while eight slots are not all taken
  wire wfRoomNext = wfAfterPush < 4'(WFIFO_DEPTH);
  wire [31:0] opStatus = {26'h0, readReq_r, rbValid, wfLevel};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    capturedAddressReg_nxt = capturedAddressReg_r;
    wrAddrNext_nxt = wrAddrNext_r;
    readAddr_nxt = readAddr_r;
    adOut_nxt = adOut_r;
    latCnt_nxt = latCnt_r;
    beN_nxt = beN_r;
    region_nxt = region_r;
    isWrite_nxt = isWrite_r;
    burst_nxt = burst_r;
    firstPhase_nxt = firstPhase_r;
    readReq_nxt = rdInFire ? 1'b0 : readReq_r;
    devselN_nxt = devselN_r;
    trdyN_nxt = trdyN_r;
    stopN_nxt = stopN_r;
    ctlOe_nxt = ctlOe_r;
    adOe_nxt = adOe_r;
    wfPush = 1'b0;
    rdPop = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // no hit, no devsel: initiator master-aborts
        if (addrPhase && (ptHit || opHit)) begin
          devselN_nxt = 1'b0;
          ctlOe_nxt = 1'b1;
          capturedAddressReg_nxt = pciIn.ad;
          latCnt_nxt = 5'h00;
          firstPhase_nxt = 1'b1;
          burst_nxt = 1'b0;
          if (opHit) begin
            // op registers answer regardless of add-on work
            state_nxt = ST_OPREG;
            trdyN_nxt = 1'b0;
            adOut_nxt = opStatus;
            adOe_nxt = ~cmdWrite;
          end else if (cmdWrite) begin
            if (wrAccept) begin
              state_nxt = ST_WRITE;
              trdyN_nxt = 1'b0;
              // status set on every accepted write, continuing ones included
              region_nxt = hitRegion;
              isWrite_nxt = 1'b1;
            end else begin
              state_nxt = ST_STOP;
              stopN_nxt = 1'b0;
            end
          end else if (rdAccept) begin
            state_nxt = ST_READ;
            adOe_nxt = 1'b1;
            // ask unless word held or arriving; an open request stays open
            readReq_nxt = ~rbValid & ~rdInFire;
            readAddr_nxt = pciIn.ad;
            region_nxt = hitRegion;
            isWrite_nxt = 1'b0;
          end else begin
            state_nxt = ST_STOP;
            stopN_nxt = 1'b0;
          end
        end
      end
      ST_WRITE: begin
        if (xfer) begin
          wfPush = 1'b1;
          beN_nxt = pciIn.cbeN;
          capturedAddressReg_nxt = capPlus4;
          wrAddrNext_nxt = capPlus4;
          // frame still low at a transfer means burst
          burst_nxt = burst_r | ~pciIn.frameN;
          if (pciIn.frameN) begin
            state_nxt = ST_TURN;
            trdyN_nxt = 1'b1;
            devselN_nxt = 1'b1;
          end else if (!nextInRegion || !wfRoomNext) begin
            state_nxt = ST_STOP;
            trdyN_nxt = 1'b1;
            stopN_nxt = 1'b0;
          end
        end
      end
      ST_READ: begin
        latCnt_nxt = latCnt_r + 5'h01;
        if (xfer) begin
          rdPop = 1'b1;
          trdyN_nxt = 1'b1;
          capturedAddressReg_nxt = capPlus4;
          readAddr_nxt = capPlus4;
          latCnt_nxt = 5'h00;
          firstPhase_nxt = 1'b0;
          burst_nxt = burst_r | ~pciIn.frameN;
          if (pciIn.frameN) begin
            state_nxt = ST_TURN;
            devselN_nxt = 1'b1;
          end else if (!nextInRegion) begin
            state_nxt = ST_STOP;
            stopN_nxt = 1'b0;
          end else begin
            readReq_nxt = 1'b1;
          end
        end else if (trdyN_r && rbValid) begin
          trdyN_nxt = 1'b0;
          adOut_nxt = rbData;
        end else if (trdyN_r && latExpired) begin
          // latency spent; request stays so late data is held
          state_nxt = ST_STOP;
          stopN_nxt = 1'b0;
        end
      end
      ST_OPREG: begin
        if (xfer) begin
          trdyN_nxt = 1'b1;
          if (pciIn.frameN) begin
            state_nxt = ST_TURN;
            devselN_nxt = 1'b1;
          end else begin
            // single dword only on op registers
            state_nxt = ST_STOP;
            stopN_nxt = 1'b0;
          end
        end
      end
      ST_STOP: begin
        // hold stop until the initiator drops frame
        if (pciIn.frameN) begin
          state_nxt = ST_TURN;
          stopN_nxt = 1'b1;
          devselN_nxt = 1'b1;
          trdyN_nxt = 1'b1;
        end
      end
      ST_TURN: begin
        // one cycle driving high before release
        state_nxt = ST_IDLE;
        ctlOe_nxt = 1'b0;
        adOe_nxt = 1'b0;
      end
      default: begin
        state_nxt = ST_IDLE;
        devselN_nxt = 1'b1;
        trdyN_nxt = 1'b1;
        stopN_nxt = 1'b1;
        ctlOe_nxt = 1'b0;
        adOe_nxt = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      capturedAddressReg_r <= 32'h0000_0000;
      wrAddrNext_r <= 32'h0000_0000;
      readAddr_r <= 32'h0000_0000;
      adOut_r <= OPST_RESET;
      latCnt_r <= 5'h00;
      beN_r <= 4'hF;
      region_r <= 2'h0;
      isWrite_r <= 1'b0;
      burst_r <= 1'b0;
      firstPhase_r <= 1'b1;
      readReq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      capturedAddressReg_r <= capturedAddressReg_nxt;
      wrAddrNext_r <= wrAddrNext_nxt;
      readAddr_r <= readAddr_nxt;
      adOut_r <= adOut_nxt;
      latCnt_r <= latCnt_nxt;
      beN_r <= beN_nxt;
      region_r <= region_nxt;
      isWrite_r <= isWrite_nxt;
      burst_r <= burst_nxt;
      firstPhase_r <= firstPhase_nxt;
      readReq_r <= readReq_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      devselN_r <= 1'b1;
      trdyN_r <= 1'b1;
      stopN_r <= 1'b1;
      ctlOe_r <= 1'b0;
      adOe_r <= 1'b0;
      busIdle_r <= 1'b1;
    end else begin
      devselN_r <= devselN_nxt;
      trdyN_r <= trdyN_nxt;
      stopN_r <= stopN_nxt;
      ctlOe_r <= ctlOe_nxt;
      adOe_r <= adOe_nxt;
      busIdle_r <= pciIn.frameN & pciIn.irdyN;
    end
  end

  // ----------------------------------------------------------------
  // add-on status and direct address read
  // ----------------------------------------------------------------
  // direct read pin is asynchronous, so it is synchronised first
  always_ff @(posedge clk) begin
    if (rst) begin
      darMeta_r <= 1'b1;
      darSync_r <= 1'b1;
      addrBusOe_r <= 1'b0;
    end else begin
      darMeta_r <= directAddressReadN;
      darSync_r <= darMeta_r;
      addrBusOe_r <= ~darSync_r;
    end
  end

  // pending while posted words or a read request wait
  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= '{accessPendingN: 1'b1, burstN: 1'b1, region: 2'h0, isWrite: 1'b0,
                    beN: 4'hF};
    end else begin
      status_r <= '{accessPendingN: ~(wrBusy | readReq_r), burstN: ~burst_r,
                    region: region_r, isWrite: isWrite_r, beN: beN_r};
    end
  end

  assign addonStatus = status_r;
  assign addrBusOut = capturedAddressReg_r;
  assign addrBusOe = addrBusOe_r;
  assign pciOut = '{devselN: devselN_r, trdyN: trdyN_r, stopN: stopN_r, ctlOe: ctlOe_r,
                    ad: adOut_r, adOe: adOe_r};
endmodule : pcipt_target

// >>> pcipt_target_chk.sv
// pcipt_target_chk: port-level assertions of the pass-through target.
// assumes pci pins and add-on side are synchronous to clk.
`timescale 1ns/1ps
module pcipt_target_chk (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire pcipt_pkg::pcipt_pci_in_t pciIn, // pci inputs
  input wire pcipt_pkg::pcipt_pci_out_t pciOut, // pci drive
  input wire pcipt_pkg::pcipt_status_t addonStatus, // status
  input wire logic wrOutValid, // drain valid
  input wire logic wrOutReady, // drain ready
  input wire logic [31:0] wrOutData, // drain word
  input wire logic rdInValid, // read word valid
  input wire logic rdInReady, // read word wanted
  input wire logic [31:0] rdInData, // read word
  input wire logic directAddressReadN, // direct read, low
  input wire logic [31:0] addrBusOut, // captured address
  input wire logic addrBusOe // address drive
);
  import pcipt_pkg::*;
  logic busIdle_r;
  logic isRead_r;
  logic addrPhase;
  logic hit;
  logic xfer;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  assign addrPhase = !pciIn.frameN && busIdle_r;
  assign hit = ((pciIn.ad & DEC_MASK[0]) == DEC_BASE[0]) ||
    ((pciIn.ad & DEC_MASK[1]) == DEC_BASE[1]) || ((pciIn.ad & DEC_MASK[2]) == DEC_BASE[2]);
  assign xfer = !pciIn.irdyN && !pciOut.trdyN && !pciOut.devselN;
  always_ff @(posedge clk) begin
    busIdle_r <= rst | (pciIn.frameN & pciIn.irdyN);
    isRead_r <= rst ? 1'b0 : (addrPhase ? !pciIn.cbeN[0] : isRead_r);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_claim_hit: assert property (addrPhase && hit |=> !pciOut.devselN)
    else $error("mapped address not claimed");
  a_no_claim: assert property (addrPhase && !hit |=> pciOut.devselN [*4])
    else $error("unmapped address claimed");
  a_addr_capture: assert property (addrPhase && hit |=> addrBusOut == $past(pciIn.ad))
    else $error("address not captured");
  a_first_wait: assert property (addrPhase && hit && !pciIn.cbeN[0]
    |-> ##[1:18] (!pciOut.trdyN || !pciOut.stopN)) else $error("first read phase too slow");
  a_next_wait: assert property (xfer && isRead_r && !pciIn.frameN && pciOut.stopN
    |-> ##[1:10] (!pciOut.trdyN || !pciOut.stopN)) else $error("later read phase too slow");
  a_stop_hold: assert property (!pciOut.stopN && !pciIn.frameN |=> !pciOut.stopN)
    else $error("stop released before frame");
  a_addr_step: assert property (xfer && !pciIn.frameN && pciOut.stopN
    |=> addrBusOut == $past(addrBusOut) + DWORD_STEP) else $error("address did not step");
  a_direct_drive: assert property ($fell(directAddressReadN) |-> ##[1:3] addrBusOe)
    else $error("captured address not driven");
  a_stall_hold: assert property (wrOutValid && !wrOutReady
    |=> wrOutValid && $stable(wrOutData)) else $error("write word lost in stall");
  c_retry: cover property (addrPhase ##1 (!pciOut.stopN && pciOut.trdyN));
  c_disc: cover property (xfer && !pciOut.stopN);
  c_full: cover property (wrOutValid && !wrOutReady ##1 !pciOut.stopN);
endmodule : pcipt_target_chk

bind pcipt_target pcipt_target_chk i_chk (.clk(clk), .rst(rst), .pciIn(pciIn),
  .pciOut(pciOut), .addonStatus(addonStatus), .wrOutValid(wrOutValid),
  .wrOutReady(wrOutReady), .wrOutData(wrOutData), .rdInValid(rdInValid),
  .rdInReady(rdInReady), .rdInData(rdInData), .directAddressReadN(directAddressReadN),
  .addrBusOut(addrBusOut), .addrBusOe(addrBusOe));

// >>> pcipt_initiator.sv
// pcipt_initiator: behavioural pci initiator for the pass-through target.
// assumes the testbench resolves the shared ad lines into adBus.
`timescale 1ns/1ps
module pcipt_initiator (
  input wire logic clk, // clock
  input wire pcipt_pkg::pcipt_pci_out_t pciOut, // target response
  input wire logic [31:0] adBus, // resolved ad lines
  output pcipt_pkg::pcipt_pci_in_t mst // initiator drive
);
  import pcipt_pkg::*;
  logic [31:0] rdata [8];
  initial mst = '{frameN:1'b1, irdyN:1'b1, cbeN:4'hF, ad:32'h0};
  // ------------------------------------------------------------
  // one transaction; cnt is -1 on a hang
  // ------------------------------------------------------------
  // frame dropped before last phase
  task automatic xfer(input logic [31:0] addr, input logic wr, input int n,
                      input logic [31:0] dat, output int cnt, output logic stopped);
    logic xf;
    logic st;
    logic ab;
    int w;
    cnt = 0;
    stopped = 1'b0;
    @(posedge clk);
    mst <= '{frameN:1'b0, irdyN:1'b1, cbeN:{3'h3, wr}, ad:addr};
    @(posedge clk);
    mst <= '{frameN:(n == 1), irdyN:1'b0, cbeN:4'h0, ad:(wr ? dat : ~addr)};
    for (w = 0; w < 40; w++) begin
      // sampled at the falling edge: what the next rising edge sees
      @(negedge clk);
      xf = !pciOut.trdyN && !pciOut.devselN;
      st = !pciOut.stopN && !pciOut.devselN;
      ab = pciOut.devselN && w > 5;
      if (xf && !wr) rdata[cnt] = adBus;
      @(posedge clk);
      if (xf) cnt++;
      stopped |= st;
      if ((mst.frameN && (xf || st)) || ab) break;
      // stop ends the burst; caller comes back
      if (st) mst.frameN <= 1'b1;
      else if (xf) begin
        mst.ad <= wr ? dat + cnt : ~addr;
        mst.frameN <= (cnt == n - 1);
      end
    end
    mst <= '{frameN:1'b1, irdyN:1'b1, cbeN:4'hF, ad:~mst.ad};
    if (w == 40) cnt = -1;
  endtask : xfer
endmodule : pcipt_initiator

// >>> pcipt_target_tb.sv
// pcipt_target_tb: scenario bench of the pass-through target.
// assumes one 40 MHz clock; the bench plays the add-on side.
`timescale 1ns/1ps
module pcipt_target_tb;
  import pcipt_pkg::*;
  logic clk;
  logic rst;
  pcipt_pci_in_t mst;
  pcipt_pci_in_t pciIn;
  pcipt_pci_out_t pciOut;
  pcipt_status_t addonStatus;
  logic wrOutValid, wrOutReady, rdInValid, rdInReady, directAddressReadN, addrBusOe;
  logic [31:0] wrOutData, rdInData, addrBusOut;
  int rdDelay, rdWait, rdWord, err_count, checked, cnt;
  logic stopped;
  // ad is shared: target drives it while adOe is high
  assign pciIn = {mst[37:32], pciOut.adOe ? pciOut.ad : mst.ad};
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  pcipt_target i_dut (.clk(clk), .rst(rst), .pciIn(pciIn), .pciOut(pciOut),
    .addonStatus(addonStatus), .wrOutValid(wrOutValid), .wrOutReady(wrOutReady),
    .wrOutData(wrOutData), .rdInValid(rdInValid), .rdInReady(rdInReady),
    .rdInData(rdInData), .directAddressReadN(directAddressReadN),
    .addrBusOut(addrBusOut), .addrBusOe(addrBusOe));
  pcipt_initiator i_mst (.clk(clk), .pciOut(pciOut), .adBus(pciIn.ad), .mst(mst));
  // ------------------------------------------------------------
  // add-on read responder: word after rdDelay cycles of demand
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rdInValid && rdInReady) begin
      rdInValid <= 1'b0;
      rdInData <= ~rdInData;
      rdWord <= rdWord + 1;
      rdWait <= 0;
    end else if (rdInReady && !rdInValid) begin
      if (rdWait >= rdDelay) begin
        rdInValid <= 1'b1;
        rdInData <= 32'hD000_0000 + rdWord;
      end else begin
        rdWait <= rdWait + 1;
      end
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [31:0] a, input logic wr, input int n, input int eCnt,
                     input logic eStop);
    i_mst.xfer(a, wr, n, 32'hA000_0000 + a, cnt, stopped);
    if (cnt < 0) begin
      err_count++;
      conclude();
    end
    chk(cnt, eCnt);
    chk(stopped, eStop);
    repeat (2) @(posedge clk);
  endtask : run
  task automatic drain(input int n, input logic [31:0] d0);
    int k;
    int w;
    wrOutReady <= 1'b1;
    for (k = 0; k < n; k++) begin
      w = 0;
      do begin
        @(negedge clk);
        w++;
      end while (!wrOutValid && w < 20);
      if (w == 20) begin
        err_count++;
        conclude();
      end
      chk(wrOutData, d0 + k);
      @(posedge clk);
    end
    wrOutReady <= 1'b0;
    @(posedge clk);
  endtask : drain
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_single_write();
    run(32'h0001_0100, 1'b1, 1, 1, 1'b0);
    @(negedge clk);
    chk({addonStatus.accessPendingN, addonStatus.burstN, addonStatus.region,
         addonStatus.isWrite}, 5'h0B);
    @(posedge clk);
    directAddressReadN <= 1'b0;
    repeat (4) @(negedge clk);
    chk({addrBusOe, addrBusOut[31:4]}, {1'b1, 28'h0001_010});
    @(posedge clk);
    directAddressReadN <= 1'b1;
    drain(1, 32'hA001_0100);
    repeat (3) @(negedge clk);
    chk(addonStatus.accessPendingN, 1'b1);
  endtask : t_single_write
  task automatic t_fill_write();
    run(32'h0001_0200, 1'b1, 10, 8, 1'b1);
    chk({addonStatus.burstN, addonStatus.beN}, 5'h00);
    run(32'h0001_0800, 1'b1, 1, 0, 1'b1);
    run(32'h0001_0220, 1'b1, 1, 0, 1'b1);
    run(32'h0003_0000, 1'b0, 1, 1, 1'b0);
    chk(i_mst.rdata[0], 32'h0000_0008);
    drain(1, 32'hA001_0200);
    run(32'h0001_0220, 1'b1, 1, 1, 1'b0);
    drain(7, 32'hA001_0201);
    drain(1, 32'hA001_0220);
  endtask : t_fill_write
  task automatic t_reads();
    rdDelay = 3;
    run(32'h0002_0010, 1'b0, 1, 1, 1'b0);
    chk(i_mst.rdata[0], 32'hD000_0000);
    run(32'h0002_0020, 1'b0, 3, 3, 1'b0);
    chk(i_mst.rdata[2], 32'hD000_0003);
    rdDelay = 20;
    run(32'h0002_0040, 1'b0, 1, 0, 1'b1);
    run(32'h0002_0080, 1'b0, 1, 0, 1'b1);
    run(32'h0002_0040, 1'b0, 1, 1, 1'b0);
    chk(i_mst.rdata[0], 32'hD000_0004);
    rdDelay = 12;
    run(32'h0002_0100, 1'b0, 3, 1, 1'b1);
    chk(i_mst.rdata[0], 32'hD000_0005);
    rdDelay = 0;
    run(32'h0002_0104, 1'b0, 1, 1, 1'b0);
    chk(i_mst.rdata[0], 32'hD000_0006);
  endtask : t_reads
  task automatic t_region_end();
    run(32'h0002_01F8, 1'b1, 4, 2, 1'b1);
    drain(2, 32'hA002_01F8);
    run(32'h0004_0000, 1'b0, 1, 0, 1'b0);
  endtask : t_region_end
  initial begin
    err_count = 0;
    checked = 0;
    rst = 1'b1;
    wrOutReady = 1'b0;
    rdInValid = 1'b0;
    rdInData = 32'h0;
    directAddressReadN = 1'b1;
    rdDelay = 0;
    rdWait = 0;
    rdWord = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_single_write();
    t_fill_write();
    t_reads();
    t_region_end();
    conclude();
  end
endmodule : pcipt_target_tb
